// *** rcp_top.sv ***
// remote control port: registers, panel keys, bus messages, serial link
`timescale 1ns/10ps
`include "rcp_defs.svh"
module rcp_top #(
	parameter int unsigned DIV_2400 = `RCP_CLK_HZ / `RCP_BAUD_2400,
	parameter int unsigned DIV_4800 = `RCP_CLK_HZ / `RCP_BAUD_4800,
	parameter int unsigned DIV_9600 = `RCP_CLK_HZ / `RCP_BAUD_9600,
	parameter int unsigned DIV_19200 = `RCP_CLK_HZ / `RCP_BAUD_19200
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// stored settings
	input wire logic [11:0] cfg_stored,
	output logic [11:0] cfg_save,
	// front panel
	input wire logic [7:0] keys,
	output logic [7:0] keys_ok,
	output logic beep,
	output logic lock_indicator,
	output logic remote_indicator,
	// interface messages
	input wire logic remote_req,
	input wire logic ren_off,
	input wire logic msg_get,
	input wire logic msg_dcl,
	input wire logic msg_llo,
	input wire logic msg_gtl,
	// measurement control
	output logic meas_trigger,
	output logic dev_clear,
	// service request and poll
	input wire logic [7:0] status_byte,
	input wire logic srq_req,
	input wire logic poll_req,
	output logic srq,
	output logic poll_valid,
	output logic [7:0] poll_data,
	// link selection
	output logic ser_en,
	output logic gpib_en,
	output logic usb_en,
	output logic [4:0] gpib_addr,
	// serial pins
	input wire logic rxd,
	output logic txd,
	// command and reply streams
	output logic [7:0] cmd_data,
	output logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_valid,
	output logic rsp_ready,
	input wire logic done_ok,
	input wire logic done_err
);
	import rcp_pkg::*;

	rcp_top_s st, nx;
	rcp_ser_if ser ();
	logic take_rsp, need_off, need_on, last, req;
	logic [7:0] pressed;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ************
	// helpers
	// ************
	function automatic rcp_cfg_s rcp_fix(input rcp_cfg_s c);
		rcp_cfg_s f;
		f = c;
		if (c.link == `RCP_LINK_BAD) f.link = `RCP_LINK_GPIB;
		if (c.addr < `RCP_ADDR_MIN || c.addr > `RCP_ADDR_MAX) begin
			f.addr = `RCP_ADDR_DEF;
		end
		return f;
	endfunction : rcp_fix

	function automatic logic [7:0] rcp_ack_char(input logic err,
		input logic [2:0] i);
		logic [7:0] c;
		c = 8'h0A;
		case ({err, i})
			4'h0: c = 8'h4F;
			4'h1: c = 8'h4B;
			4'h8: c = 8'h45;
			4'h9: c = 8'h52;
			4'hA: c = 8'h52;
			4'hB: c = 8'h4F;
			4'hC: c = 8'h52;
			default: c = 8'h0A;
		endcase
		return c;
	endfunction : rcp_ack_char

	// ************
	// serial engine
	// ************
	always_comb begin
		case (st.act.baud)
			2'h0: ser.div = 17'(DIV_2400);
			2'h1: ser.div = 17'(DIV_4800);
			2'h2: ser.div = 17'(DIV_9600);
			default: ser.div = 17'(DIV_19200);
		endcase
	end
	assign ser.bits7 = st.act.bits7;
	assign ser.stop2 = !st.act.stop1;
	assign ser.en = st.ser_en;
	assign ser.tx_data = st.tx_d;
	assign ser.tx_valid = st.tx_v;

	rcp_uart u_uart (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.rxd(rxd),
		.txd(txd),
		.ser(ser)
	);

	// ************
	// next state
	// ************
	always_comb begin
		nx = st;
		nx.trig = 1'b0;
		nx.clr = 1'b0;
		nx.beep = 1'b0;
		req = avs_read || avs_write;
		// settings caught once after each reset
		if (!st.loaded) begin
			nx.loaded = 1'b1;
			nx.pend = rcp_fix(cfg_stored);
			nx.act = rcp_fix(cfg_stored);
		end
		nx.ser_en = nx.act.link == `RCP_LINK_SER;
		nx.gpib_en = nx.act.link == `RCP_LINK_GPIB;
		nx.usb_en = nx.act.link == `RCP_LINK_USB;
		nx.addr = nx.act.addr;
		// avalon slave: one wait cycle, then complete
		if (req && st.wreq) begin
			nx.wreq = 1'b0;
			case (avs_address)
				`RCP_REG_CFG: nx.rdata = {20'h00000, st.pend};
				`RCP_REG_ACT: nx.rdata = {20'h00000, st.act};
				`RCP_REG_STAT: nx.rdata = {28'h0000000, st.paused,
					st.lockout, st.remote, st.locked};
				default: nx.rdata = 32'h00000000;
			endcase
		end else if (req) begin
			nx.wreq = 1'b1;
			if (avs_write && avs_address == `RCP_REG_CFG) begin
				if (avs_writedata[`RCP_INIT_BIT]) begin
					nx.pend = `RCP_CFG_DEF;
				end else begin
					nx.pend = rcp_fix(avs_writedata[11:0]);
				end
			end
		end
		// ************
		// front panel
		// ************
		pressed = keys & (st.locked ? `RCP_KEYS_LOCKED : 8'hFF);
		if (st.lockout) pressed[`RCP_KEY_LOCAL] = 1'b0;
		nx.keys_ok = pressed;
		if (pressed[`RCP_KEY_LOCK]) begin
			nx.locked = !st.locked;
			nx.beeps = st.locked ? 2'h2 : 2'h1;
			nx.gap = 6'h00;
		end else if (st.gap != 6'h00) begin
			nx.gap = st.gap - 6'h01;
		end else if (st.beeps != 2'h0) begin
			nx.beep = 1'b1;
			nx.beeps = st.beeps - 2'h1;
			nx.gap = `RCP_BEEP_GAP;
		end
		// ************
		// remote and local
		// ************
		if (remote_req) nx.remote = 1'b1;
		if (msg_llo && !st.ser_en) nx.lockout = 1'b1;
		if (pressed[`RCP_KEY_LOCAL]) nx.remote = 1'b0;
		if (msg_gtl && !st.ser_en) nx.remote = 1'b0;
		if (ren_off) begin
			nx.remote = 1'b0;
			nx.lockout = 1'b0;
		end
		// ************
		// trigger, clear, service request
		// ************
		nx.trig = msg_get && !st.ser_en;
		nx.clr = (msg_dcl && !st.ser_en)
			|| (ser.rx_brk && st.ser_en);
		nx.srq = srq_req && !nx.ser_en;
		nx.poll_v = poll_req && !nx.ser_en;
		if (poll_req) nx.poll_d = {status_byte[7], srq_req, status_byte[5:0]};
		// ************
		// receive path
		// ************
		if (st.cmd_v && cmd_ready) nx.cmd_v = 1'b0;
		if (ser.rx_valid) begin
			if (ser.rx_data == `RCP_XOFF) begin
				nx.paused = 1'b1;
			end else if (ser.rx_data == `RCP_XON) begin
				nx.paused = 1'b0;
			end else begin
				nx.cmd_d = st.act.bits7 ? {1'b0, ser.rx_data[6:0]}
					: ser.rx_data;
				nx.cmd_v = 1'b1;
			end
		end
		if (nx.clr) nx.cmd_v = 1'b0;
		// ************
		// transmit path
		// ************
		need_off = st.cmd_v && !cmd_ready && !st.xoff_sent;
		need_on = !st.cmd_v && st.xoff_sent;
		take_rsp = st.rsp_rdy && rsp_valid;
		last = st.ack_i == (st.ack_err ? `RCP_ACK_ERR_LAST
			: `RCP_ACK_OK_LAST);
		if ((done_ok || done_err) && st.act.ack && st.ser_en
			&& !st.ack_on) begin
			nx.ack_on = 1'b1;
			nx.ack_err = done_err;
			nx.ack_i = 3'h0;
		end
		if (st.tx_v && ser.tx_ready) nx.tx_v = 1'b0;
		if (take_rsp) begin
			nx.tx_v = 1'b1;
			nx.tx_d = rsp_data;
		end else if (!st.tx_v && st.ser_en && (need_off || need_on)) begin
			nx.tx_v = 1'b1;
			nx.tx_d = need_off ? `RCP_XOFF : `RCP_XON;
			nx.xoff_sent = need_off;
		end else if (!st.tx_v && st.ack_on && !st.paused) begin
			nx.tx_v = 1'b1;
			nx.tx_d = rcp_ack_char(st.ack_err, st.ack_i);
			nx.ack_i = st.ack_i + 3'h1;
			if (last) nx.ack_on = 1'b0;
		end
		if (!st.ser_en) begin
			nx.tx_v = 1'b0;
			nx.ack_on = 1'b0;
		end
		nx.rsp_rdy = st.ser_en && !nx.paused && !nx.tx_v && !take_rsp
			&& !nx.ack_on && !need_off && !need_on;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.wreq <= 1'b1;
			st.pend <= `RCP_CFG_DEF;
			st.act <= `RCP_CFG_DEF;
			st.gpib_en <= 1'b1;
			st.addr <= `RCP_ADDR_DEF;
		end else if (ce) begin
			st <= nx;
		end
	end

	// ************
	// outputs
	// ************
	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.wreq;
	assign cfg_save = st.pend;
	assign keys_ok = st.keys_ok;
	assign beep = st.beep;
	assign lock_indicator = st.locked;
	assign remote_indicator = st.remote;
	assign meas_trigger = st.trig;
	assign dev_clear = st.clr;
	assign srq = st.srq;
	assign poll_valid = st.poll_v;
	assign poll_data = st.poll_d;
	assign ser_en = st.ser_en;
	assign gpib_en = st.gpib_en;
	assign usb_en = st.usb_en;
	assign gpib_addr = st.addr;
	assign cmd_data = st.cmd_d;
	assign cmd_valid = st.cmd_v;
	assign rsp_ready = st.rsp_rdy;

	// ************
	// checks
	// ************
	a_lock_keys: assert property (ce && st.locked |=>
		(keys_ok & ~`RCP_KEYS_LOCKED) == 8'h00)
		else $error("key passed while panel locked");
	a_lock_beeps: assert property (ce && keys[`RCP_KEY_LOCK] |=>
		st.beeps == ($past(st.locked) ? 2'h2 : 2'h1)
		&& lock_indicator != $past(lock_indicator))
		else $error("lock toggle or beep count wrong");
	a_local_key: assert property (ce && remote_indicator
		&& keys[`RCP_KEY_LOCAL] && !st.lockout && !st.locked
		|=> !remote_indicator)
		else $error("local key did not leave remote");
	a_one_link: assert property ($onehot({ser_en, gpib_en, usb_en}))
		else $error("not exactly one link active");
	a_addr_range: assert property (gpib_addr >= `RCP_ADDR_MIN
		&& gpib_addr <= `RCP_ADDR_MAX)
		else $error("bus address out of range");
	a_get_trig: assert property (ce && msg_get && !ser_en
		|=> meas_trigger)
		else $error("trigger message did not start measurement");
	a_clear_buf: assert property (ce && msg_dcl && !ser_en
		|=> dev_clear && !cmd_valid)
		else $error("device clear did not abort and flush");
	a_break_clear: assert property (ce && ser.rx_brk && ser_en
		|=> dev_clear && !cmd_valid)
		else $error("break did not act as device clear");
	a_lockout_key: assert property (ce && st.lockout && remote_indicator
		&& !msg_gtl && !ren_off |=> remote_indicator)
		else $error("remote left while locked out");
	a_gtl_local: assert property (ce && msg_gtl && !ser_en
		|=> !remote_indicator)
		else $error("go-to-local ignored");
	a_srq_link: assert property (srq || poll_valid |-> !ser_en)
		else $error("service request on serial link");
	a_xoff_halt: assert property (ce && st.paused && !st.tx_v
		&& !st.rsp_rdy |=> !st.tx_v || st.tx_d == `RCP_XON
		|| st.tx_d == `RCP_XOFF)
		else $error("new character sent while paused");
	a_ack_off: assert property (!st.act.ack |-> !st.ack_on)
		else $error("reply sent with replies disabled");
endmodule : rcp_top

// *** rcp_defs.svh ***
// constants of the remote control port
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH
`define RCP_CLK_HZ 250000000
`define RCP_BAUD_2400 2400
`define RCP_BAUD_4800 4800
`define RCP_BAUD_9600 9600
`define RCP_BAUD_19200 19200
`define RCP_REG_CFG 4'h0
`define RCP_REG_ACT 4'h4
`define RCP_REG_STAT 4'h8
`define RCP_INIT_BIT 31
`define RCP_LINK_SER 2'h0
`define RCP_LINK_GPIB 2'h1
`define RCP_LINK_USB 2'h2
`define RCP_LINK_BAD 2'h3
`define RCP_ADDR_MIN 5'h01
`define RCP_ADDR_MAX 5'h1E
`define RCP_ADDR_DEF 5'h03
`define RCP_CFG_DEF 12'h18D
`define RCP_XON 8'h11
`define RCP_XOFF 8'h13
`define RCP_KEY_LOAD 0
`define RCP_KEY_RECALL 1
`define RCP_KEY_LOCK 2
`define RCP_KEY_LOCAL 3
`define RCP_KEYS_LOCKED 8'h07
`define RCP_BEEP_GAP 6'h20
`define RCP_ACK_OK_LAST 3'h2
`define RCP_ACK_ERR_LAST 3'h5
`endif

// *** rcp_pkg.sv ***
// types of the remote control port
package rcp_pkg;
	typedef struct packed {
		logic ack;
		logic stop1;
		logic bits7;
		logic [1:0] baud;
		logic [4:0] addr;
		logic [1:0] link;
	} rcp_cfg_s;
	typedef struct packed {
		logic loaded;
		rcp_cfg_s pend;
		rcp_cfg_s act;
		logic wreq;
		logic [31:0] rdata;
		logic [7:0] keys_ok;
		logic locked, remote, lockout;
		logic [1:0] beeps;
		logic [5:0] gap;
		logic beep, trig, clr, srq, poll_v;
		logic [7:0] poll_d;
		logic ser_en, gpib_en, usb_en;
		logic [4:0] addr;
		logic [7:0] cmd_d;
		logic cmd_v, rsp_rdy;
		logic [7:0] tx_d;
		logic tx_v, paused, xoff_sent, ack_on, ack_err;
		logic [2:0] ack_i;
	} rcp_top_s;
	typedef struct packed {
		logic txd, tx_busy;
		logic [16:0] tx_c;
		logic [3:0] tx_n;
		logic [10:0] tx_sh;
		logic rx_busy;
		logic [16:0] rx_c;
		logic [3:0] rx_n;
		logic rx_v;
		logic [7:0] rx_d;
		logic [16:0] lo_c;
		logic [3:0] lo_n;
		logic brk_done, brk;
	} rcp_uart_s;
endpackage : rcp_pkg

// *** rcp_ser_if.sv ***
// carrier between the port core and its serial engine
`timescale 1ns/10ps
interface rcp_ser_if;
	logic [16:0] div;
	logic bits7, stop2, en;
	logic [7:0] tx_data, rx_data;
	logic tx_valid, tx_ready, rx_valid, rx_brk;
	modport core (output div, bits7, stop2, en, tx_data, tx_valid,
		input tx_ready, rx_data, rx_valid, rx_brk);
	modport phy (input div, bits7, stop2, en, tx_data, tx_valid,
		output tx_ready, rx_data, rx_valid, rx_brk);
endinterface : rcp_ser_if

// *** rcp_uart.sv ***
// serial character engine with break detection
`timescale 1ns/10ps
`include "rcp_defs.svh"
module rcp_uart (
	// clock and control
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// pins
	input wire logic rxd,
	output logic txd,
	// core side
	rcp_ser_if.phy ser
);
	import rcp_pkg::*;
	rcp_uart_s st, nx;
	logic [3:0] nbits, frame;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	always_comb begin
		nbits = ser.bits7 ? 4'h7 : 4'h8;
		frame = 4'h1 + nbits + (ser.stop2 ? 4'h2 : 4'h1);
		nx = st;
		nx.rx_v = 1'b0;
		nx.brk = 1'b0;
		// ************
		// transmitter
		// ************
		if (!st.tx_busy) begin
			if (ser.tx_valid && ser.en) begin
				nx.tx_busy = 1'b1;
				nx.tx_sh = {2'h3, ser.bits7 | ser.tx_data[7],
					ser.tx_data[6:0], 1'b0};
				nx.txd = 1'b0;
				nx.tx_n = frame;
				nx.tx_c = ser.div - 17'h00001;
			end
		end else if (st.tx_c == 17'h00000) begin
			nx.tx_c = ser.div - 17'h00001;
			nx.tx_sh = {1'b1, st.tx_sh[10:1]};
			nx.txd = st.tx_sh[1];
			nx.tx_n = st.tx_n - 4'h1;
			if (st.tx_n == 4'h1) begin
				nx.tx_busy = 1'b0;
				nx.txd = 1'b1;
			end
		end else begin
			nx.tx_c = st.tx_c - 17'h00001;
		end
		// ************
		// receiver
		// ************
		if (!st.rx_busy) begin
			if (ser.en && !rxd && !st.brk_done) begin
				nx.rx_busy = 1'b1;
				nx.rx_c = {1'b0, ser.div[16:1]};
				nx.rx_n = 4'h0;
				nx.rx_d = 8'h00;
			end
		end else if (st.rx_c == 17'h00000) begin
			nx.rx_c = ser.div - 17'h00001;
			nx.rx_n = st.rx_n + 4'h1;
			if (st.rx_n == 4'h0) begin
				nx.rx_busy = !rxd;
			end else if (st.rx_n <= nbits) begin
				nx.rx_d[st.rx_n[2:0] - 3'h1] = rxd;
			end else begin
				nx.rx_busy = 1'b0;
				nx.rx_v = rxd;
			end
		end else begin
			nx.rx_c = st.rx_c - 17'h00001;
		end
		// ************
		// break detector
		// ************
		if (rxd || !ser.en) begin
			nx.lo_c = ser.div - 17'h00001;
			nx.lo_n = 4'h0;
			nx.brk_done = 1'b0;
		end else if (st.lo_c == 17'h00000) begin
			nx.lo_c = ser.div - 17'h00001;
			if (st.lo_n != 4'hF) nx.lo_n = st.lo_n + 4'h1;
		end else begin
			nx.lo_c = st.lo_c - 17'h00001;
		end
		if (st.lo_n > frame && !st.brk_done) begin
			nx.brk = 1'b1;
			nx.brk_done = 1'b1;
			nx.rx_busy = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.txd <= 1'b1;
		end else if (ce) begin
			st <= nx;
		end
	end

	assign txd = st.txd;
	assign ser.tx_ready = !st.tx_busy && ser.en;
	assign ser.rx_data = st.rx_d;
	assign ser.rx_valid = st.rx_v;
	assign ser.rx_brk = st.brk;

	a_break_len: assert property (ser.rx_brk |-> st.lo_n > frame)
		else $error("break flagged before a whole frame of space");
	a_tx_idle_mark: assert property (!st.tx_busy |-> txd)
		else $error("serial output not at mark while idle");
endmodule : rcp_uart

// *** rcp_host.sv ***
// serial host model facing the remote control port
`timescale 1ns/10ps
module rcp_host (
	// clock
	input wire logic clk_sys,
	// serial pins
	input wire logic txd,
	output logic rxd
);
	int bt = 8;
	int nb = 8;
	int ns = 2;
	logic [7:0] rxq[$];
	logic [7:0] sh;
	initial rxd = 1'h1;
	// ****
	// sending, lsb first, no parity
	// ****
	task automatic send(input logic [7:0] d);
		@(posedge clk_sys);
		rxd <= 1'h0;
		repeat (bt) @(posedge clk_sys);
		for (int i = 0; i < nb; i++) begin
			rxd <= d[i];
			repeat (bt) @(posedge clk_sys);
		end
		rxd <= 1'h1;
		repeat (bt * ns) @(posedge clk_sys);
	endtask : send
	task automatic brk(input int n);
		@(posedge clk_sys);
		rxd <= 1'h0;
		repeat (bt * n) @(posedge clk_sys);
		rxd <= 1'h1;
		repeat (bt * 4) @(posedge clk_sys);
	endtask : brk
	// ****
	// receiving, runs while sending
	// ****
	always begin
		@(posedge clk_sys);
		if (txd === 1'h0) begin
			sh = 8'h00;
			repeat (bt / 2) @(posedge clk_sys);
			for (int i = 0; i < nb; i++) begin
				repeat (bt) @(posedge clk_sys);
				sh[i] = txd;
			end
			repeat (bt) @(posedge clk_sys);
			if (txd === 1'h1) begin
				rxq.push_back(sh);
			end
		end
	end
endmodule : rcp_host

// *** rcp_top_test.sv ***
// self-checking testbench of the remote control port
`timescale 1ns/10ps
`include "rcp_defs.svh"
module rcp_top_test;
	localparam int BT [4] = '{64, 32, 16, 8};
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [11:0] cfg_stored = 12'h18D;
	logic [16:0] ev = 17'h0;
	logic [7:0] status_byte = 8'h0;
	logic [7:0] rsp_data = 8'h0;
	logic srq_req = 1'h0;
	logic cmd_ready = 1'h1;
	logic rsp_valid = 1'h0;
	logic [31:0] avs_readdata, rdat;
	logic [11:0] cfg_save;
	logic [7:0] keys_ok, poll_data, cmd_data;
	logic [4:0] gpib_addr;
	logic avs_waitrequest, beep, lock_indicator, remote_indicator;
	logic meas_trigger, dev_clear, srq, poll_valid, ser_en, gpib_en;
	logic usb_en, rxd, txd, cmd_valid, rsp_ready;
	logic [7:0] cmdq[$];
	int err_count = 0;
	int checks = 0;
	int nbeep = 0;
	int nclr = 0;
	rcp_top #(.DIV_2400(BT[0]), .DIV_4800(BT[1]), .DIV_9600(BT[2]),
		.DIV_19200(BT[3])) dut_u (
		.clk_sys, .rst, .ce, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .cfg_stored,
		.cfg_save, .keys(ev[7:0]), .keys_ok, .beep, .lock_indicator,
		.remote_indicator, .remote_req(ev[12]), .ren_off(ev[13]),
		.msg_get(ev[8]), .msg_dcl(ev[9]), .msg_llo(ev[10]),
		.msg_gtl(ev[11]), .meas_trigger, .dev_clear, .status_byte,
		.srq_req, .poll_req(ev[14]), .srq, .poll_valid, .poll_data,
		.ser_en, .gpib_en, .usb_en, .gpib_addr, .rxd, .txd, .cmd_data,
		.cmd_valid, .cmd_ready, .rsp_data, .rsp_valid, .rsp_ready,
		.done_ok(ev[15]), .done_err(ev[16]));
	rcp_host host_u (.clk_sys, .txd, .rxd);
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (beep === 1'h1) nbeep++;
		if (dev_clear === 1'h1) nclr++;
		if (cmd_valid === 1'h1 && cmd_ready === 1'h1) begin
			cmdq.push_back(cmd_data);
		end
	end
	// ****
	// shared tasks
	// ****
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [47:0] e, g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	task automatic do_reset(input logic [11:0] c);
		@(posedge clk_sys);
		cfg_stored <= c;
		rst <= 1'h1;
		repeat (12) @(posedge clk_sys);
		rst <= 1'h0;
		idle(3);
	endtask : do_reset
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		rdat = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		#1;
		if (n >= 20) begin
			chk("bus wait", 1, 0);
			end_sim;
		end
	endtask : bus
	task automatic rdr(input logic [3:0] a, input logic [47:0] e,
		input string n);
		bus(1'h0, a, 32'h0);
		chk(n, e, rdat);
	endtask : rdr
	task automatic pulse(input int b);
		@(posedge clk_sys);
		ev[b] <= 1'h1;
		@(posedge clk_sys);
		ev[b] <= 1'h0;
		#1;
	endtask : pulse
	task automatic send_rsp(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk_sys);
		rsp_data <= b;
		rsp_valid <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp_ready !== 1'h1 && n < 5000);
		rsp_valid <= 1'h0;
		#1;
		if (n >= 5000) begin
			chk("rsp wait", 1, 0);
			end_sim;
		end
	endtask : send_rsp
	task automatic wait_rx(input int n);
		int c;
		c = 0;
		while (host_u.rxq.size() < n && c < 5000) begin
			@(posedge clk_sys);
			c++;
		end
		#1;
		if (c >= 5000) begin
			chk("rx wait", 1, 0);
			end_sim;
		end
	endtask : wait_rx
	function automatic logic [47:0] rxw(input int n);
		logic [47:0] w;
		w = 48'h0;
		for (int k = 0; k < n; k++) w = {w[39:0], host_u.rxq[k]};
		return w;
	endfunction : rxw
	// ****
	// scenarios
	// ****
	task automatic t_cfg;
		logic [11:0] c[4] = '{12'h1F9, 12'h1FD, 12'h18F, 12'h18E};
		logic [7:0] e[4] = '{8'h5E, 8'h43, 8'h43, 8'h23};
		rdr(`RCP_REG_CFG, 48'h18D, "cfg");
		bus(1'h1, `RCP_REG_CFG, 32'h994);
		chk("cfg_save", 48'h994, cfg_save);
		rdr(`RCP_REG_ACT, 48'h18D, "act");
		chk("addr held", 48'h3, gpib_addr);
		bus(1'h1, `RCP_REG_ACT, 32'h0);
		rdr(`RCP_REG_ACT, 48'h18D, "act ro");
		rdr(4'hC, 48'h0, "unmapped");
		bus(1'h1, `RCP_REG_CFG, 32'h8000_0000);
		rdr(`RCP_REG_CFG, 48'h18D, "factory");
		for (int i = 0; i < 4; i++) begin
			do_reset(c[i]);
			chk("link addr", e[i], {ser_en, gpib_en, usb_en, gpib_addr});
		end
		do_reset(12'h18D);
		$display("cfg done");
	endtask : t_cfg
	task automatic t_lock;
		nbeep = 0;
		pulse(2);
		idle(100);
		chk("beeps on", 1, nbeep);
		chk("lock ind", 1, lock_indicator);
		for (int k = 0; k < 8; k++) begin
			if (k != 2) begin
				pulse(k);
				chk("locked key", k < 2 ? 8'h01 << k : 8'h0, keys_ok);
			end
		end
		pulse(2);
		idle(100);
		chk("beeps off", 3, nbeep);
		chk("unlock ind", 0, lock_indicator);
		pulse(4);
		chk("free key", 48'h10, keys_ok);
		$display("lock done");
	endtask : t_lock
	task automatic t_remote;
		pulse(12);
		chk("remote", 1, remote_indicator);
		pulse(3);
		chk("local", 0, remote_indicator);
		pulse(12);
		pulse(10);
		pulse(3);
		chk("lockout", 1, remote_indicator);
		rdr(`RCP_REG_STAT, 48'h6, "stat");
		pulse(11);
		chk("gtl", 0, remote_indicator);
		pulse(13);
		rdr(`RCP_REG_STAT, 48'h0, "stat off");
		$display("remote done");
	endtask : t_remote
	task automatic t_msgs;
		ce <= 1'h0;
		pulse(12);
		chk("frozen", 0, remote_indicator);
		ce <= 1'h1;
		status_byte <= 8'hA5;
		srq_req <= 1'h1;
		pulse(8);
		chk("trigger", 1, meas_trigger);
		idle(1);
		chk("trigger end", 0, meas_trigger);
		pulse(9);
		chk("clear", 1, dev_clear);
		chk("srq", 1, srq);
		pulse(14);
		chk("poll", 48'h1E5, {poll_valid, poll_data});
		srq_req <= 1'h0;
		$display("msgs done");
	endtask : t_msgs
	task automatic t_rate;
		logic [11:0] c;
		logic [7:0] m;
		logic [47:0] g;
		for (int i = 0; i < 4; i++) begin
			c = {1'h0, i[1], i[0], i[1:0], 5'h03, 2'h0};
			m = i[0] ? 8'h7F : 8'hFF;
			do_reset(c);
			host_u.bt = BT[i];
			host_u.nb = i[0] ? 7 : 8;
			host_u.ns = i[1] ? 1 : 2;
			host_u.rxq.delete();
			cmdq.delete();
			nclr = 0;
			chk("ser_en", 48'h4, {ser_en, gpib_en, usb_en});
			pulse(8);
			chk("get on serial", 0, meas_trigger);
			host_u.send(8'hA5);
			host_u.send(8'h00);
			idle(8);
			g = {cmdq[0], cmdq[1]};
			chk("rx", {8'hA5 & m, 8'h00}, g);
			pulse(15);
			send_rsp(8'hC3);
			wait_rx(1);
			idle(1000);
			g = {host_u.rxq.size(), host_u.rxq[0]};
			chk("tx", {32'h1, 8'hC3 & m}, g);
			chk("no break", 0, nclr);
			host_u.brk(14);
			idle(4);
			chk("break", 1, nclr);
			idle(BT[i] * 4);
			chk("break flush", 2, cmdq.size());
		end
		$display("rate done");
	endtask : t_rate
	task automatic t_flow;
		do_reset(12'h98C);
		host_u.bt = BT[3];
		host_u.nb = 8;
		host_u.ns = 2;
		cmdq.delete();
		host_u.rxq.delete();
		cmd_ready <= 1'h0;
		host_u.send(8'h41);
		wait_rx(1);
		chk("xoff out", `RCP_XOFF, host_u.rxq[0]);
		cmd_ready <= 1'h1;
		wait_rx(2);
		chk("xon out", `RCP_XON, host_u.rxq[1]);
		host_u.send(`RCP_XOFF);
		rdr(`RCP_REG_STAT, 48'h8, "paused");
		host_u.rxq.delete();
		fork
			send_rsp(8'h55);
			begin
				idle(600);
				chk("halted", 0, host_u.rxq.size());
				chk("rsp held", 0, rsp_ready);
				host_u.send(`RCP_XON);
			end
		join
		wait_rx(1);
		chk("resumed", 48'h55, host_u.rxq[0]);
		chk("consumed", 1, cmdq.size());
		host_u.rxq.delete();
		pulse(15);
		wait_rx(3);
		chk("ok", 48'h4F4B0A, rxw(3));
		host_u.rxq.delete();
		pulse(16);
		wait_rx(6);
		chk("error", 48'h4552524F520A, rxw(6));
		$display("flow done");
	endtask : t_flow
	initial begin
		do_reset(12'h18D);
		t_cfg;
		t_lock;
		t_remote;
		t_msgs;
		t_rate;
		t_flow;
		end_sim;
	end
endmodule : rcp_top_test
